//--- uic_consts.svh
// Command codes, field positions, reset values and timing counts of the init command block
`ifndef UIC_CONSTS_SVH
`define UIC_CONSTS_SVH

`define UIC_CMD_SET_ADDR      8'hD0
`define UIC_CMD_SET_EP_EN     8'hD8
`define UIC_CMD_SET_MODE      8'hF3
`define UIC_CMD_FRAME_RD      8'hF5
`define UIC_CMD_RESUME        8'hF6
`define UIC_CMD_SEL_LO        8'h00
`define UIC_CMD_SEL_HI        8'h05
`define UIC_CMD_LTS_LO        8'h40
`define UIC_CMD_LTS_HI        8'h45
`define UIC_CMD_EPS_LO        8'h80
`define UIC_CMD_EPS_HI        8'h85

`define UIC_ADDR_RST          7'h00
`define UIC_FEN_RST           1'b0
`define UIC_EPEN_BIT          0
`define UIC_CFG_RST           8'h0E
`define UIC_CFG_NOSUSPCLK     1
`define UIC_CFG_CLKRUN        2
`define UIC_CFG_NAKINT        3
`define UIC_CFG_PULLUP        4
`define UIC_CFG_EPMODE_HI     7
`define UIC_CFG_EPMODE_LO     6
`define UIC_DIV_RST           8'h0B
`define UIC_DIV_VAL_HI        3
`define UIC_DIV_OFF           4'hF
`define UIC_DIV_SOFONLY       7

`define UIC_SYS_CLK_HZ        25000000
`define UIC_SUSP_CLK_HZ       30000
`define UIC_SUSP_HALF_CYC     (`UIC_SYS_CLK_HZ / (2 * `UIC_SUSP_CLK_HZ))
`define UIC_CNT_W             10

`endif

//--- uic_pkg.sv
// Types shared by the init command block
package uic_pkg;

  typedef enum logic [3:0]
  {
    UIC_IDLE,
    UIC_ADDR_WR,
    UIC_EPEN_WR,
    UIC_MODE_WR1,
    UIC_MODE_WR2,
    UIC_FRAME_RD1,
    UIC_FRAME_RD2,
    UIC_SEL_RD,
    UIC_LTS_RW,
    UIC_EPS_RD,
    UIC_DONE
  } uic_state_t;

  typedef enum logic [1:0]
  {
    UIC_EP_NONISO,
    UIC_EP_ISO_OUT,
    UIC_EP_ISO_IN,
    UIC_EP_ISO_IO
  } uic_epmode_t;

endpackage : uic_pkg

//--- uic_clock_output_pin_gen.sv
// Clock output divider with suspend slow-down and off setting
`timescale 1ns/1ps
`include "uic_consts.svh"

module uic_clock_output_pin_gen
  import uic_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  // Settings
  input  wire logic [3:0] output_divider_value,
  input  wire logic       no_suspend_clk,
  input  wire logic       usb_suspend,
  // Pin
  output logic            clock_output_pin
);

  logic [`UIC_CNT_W-1:0] cnt_q;
  logic [`UIC_CNT_W-1:0] cnt_d;
  logic                  pin_q;
  logic                  pin_d;
  logic [`UIC_CNT_W-1:0] half_cyc;
  logic                  off;

  always_comb
  begin
    off   = (output_divider_value == `UIC_DIV_OFF);
    // Half period in sys_clk cycles: divider value plus one, or the slow suspend rate
    if (usb_suspend && !no_suspend_clk)
      half_cyc = `UIC_CNT_W'(`UIC_SUSP_HALF_CYC);
    else
      half_cyc = `UIC_CNT_W'(output_divider_value);
    cnt_d = cnt_q + `UIC_CNT_W'(1);
    pin_d = pin_q;
    if (off)
    begin
      cnt_d = '0;
      pin_d = 1'b0;
    end
    else if (cnt_q >= half_cyc)
    begin
      cnt_d = '0;
      pin_d = ~pin_q;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      pin_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pin_q <= pin_d;
    end
  end

  assign clock_output_pin = pin_q;

endmodule : uic_clock_output_pin_gen

//--- uic_int_sel.sv
// Interrupt pin source selection
`timescale 1ns/1ps
`include "uic_consts.svh"

module uic_int_sel
  import uic_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Sources and modes
  input  wire logic int_reg_any,
  input  wire logic sof_rx,
  input  wire logic sof_only_mode,
  input  wire logic int_pin_mode,
  // Pin
  output logic      int_n
);

  logic int_q;
  logic int_d;

  always_comb
  begin
    if (sof_only_mode)
      int_d = sof_rx;
    else if (int_pin_mode)
      int_d = sof_rx | int_reg_any;
    else
      int_d = int_reg_any;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      int_q <= 1'b0;
    else
      int_q <= int_d;
  end

  assign int_n = ~int_q;

endmodule : uic_int_sel

//--- uic_cmd_init.sv
// Command decoder and initialization registers of the USB device controller
`timescale 1ns/1ps
`include "uic_consts.svh"


module uic_cmd_init
  import uic_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // Microcontroller command bus
  input  wire logic        cmd_wr,
  input  wire logic        data_wr,
  input  wire logic        data_rd,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out,
  // USB engine status
  input  wire logic        usb_bus_reset,
  input  wire logic        usb_suspend,
  input  wire logic        vbus_present,
  input  wire logic        sof_rx,
  input  wire logic        int_reg_any,
  input  wire logic        dma_int_pin_mode,
  input  wire logic [10:0] frame_number,
  input  wire logic [7:0]  ep_select_status,
  input  wire logic [7:0]  ep_last_status,
  input  wire logic [7:0]  ep_status,
  // Endpoint engine controls
  output logic [2:0]       ep_index,
  output logic             ep_select_pulse,
  output logic             ep_last_status_rd,
  output logic             ep_status_wr,
  output logic [7:0]       ep_status_wr_data,
  output logic             send_resume,
  // Initialization settings
  output logic [6:0]       device_address,
  output logic             function_enable,
  output logic             control_endpoint_enable,
  output logic             secondary_endpoint_enable,
  output logic             primary_endpoint_enable,
  output uic_epmode_t      primary_endpoint_mode,
  output logic             nak_err_int_enable,
  output logic             internal_clk_run,
  output logic             dplus_pullup_control,
  output logic             must_be_one_bit,
  // Pins
  output logic             clock_output_pin,
  output logic             int_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode

  function automatic uic_state_t cmd_decode(input logic [7:0] code);
    uic_state_t st;
    st = UIC_DONE;
    if (code == `UIC_CMD_SET_ADDR)
      st = UIC_ADDR_WR;
    else if (code == `UIC_CMD_SET_EP_EN)
      st = UIC_EPEN_WR;
    else if (code == `UIC_CMD_SET_MODE)
      st = UIC_MODE_WR1;
    else if (code == `UIC_CMD_FRAME_RD)
      st = UIC_FRAME_RD1;
    else if (code <= `UIC_CMD_SEL_HI)
      st = UIC_SEL_RD;
    else if (code >= `UIC_CMD_LTS_LO && code <= `UIC_CMD_LTS_HI)
      st = UIC_LTS_RW;
    else if (code >= `UIC_CMD_EPS_LO && code <= `UIC_CMD_EPS_HI)
      st = UIC_EPS_RD;
    return st;
  endfunction : cmd_decode

  ////////////////////////////////////////////////////////////////////////////
  // State

  uic_state_t  state_q;
  uic_state_t  state_d;
  logic [6:0]  addr_q;
  logic [6:0]  addr_d;
  logic        fen_q;
  logic        fen_d;
  logic        epen_q;
  logic        epen_d;
  logic [7:0]  cfg_q;
  logic [7:0]  cfg_d;
  logic [7:0]  div_q;
  logic [7:0]  div_d;
  logic [7:0]  rd_q;
  logic [7:0]  rd_d;
  logic [2:0]  idx_q;
  logic [2:0]  idx_d;
  logic        sel_q;
  logic        sel_d;
  logic        lts_q;
  logic        lts_d;
  logic        epw_q;
  logic        epw_d;
  logic [7:0]  epw_data_q;
  logic [7:0]  epw_data_d;
  logic        res_q;
  logic        res_d;

  always_comb
  begin
    state_d    = state_q;
    addr_d     = addr_q;
    fen_d      = fen_q;
    epen_d     = epen_q;
    cfg_d      = cfg_q;
    div_d      = div_q;
    rd_d       = rd_q;
    idx_d      = idx_q;
    epw_data_d = epw_data_q;
    sel_d      = 1'b0;
    lts_d      = 1'b0;
    epw_d      = 1'b0;
    res_d      = 1'b0;

    if (cmd_wr)
    begin
      // A new command always restarts decoding
      state_d = cmd_decode(data_in);
      idx_d   = data_in[2:0];
      sel_d   = (data_in <= `UIC_CMD_SEL_HI);
      res_d   = (data_in == `UIC_CMD_RESUME);
    end
    else if (data_wr)
    begin
      case (state_q)
        UIC_ADDR_WR:
        begin
          addr_d  = data_in[6:0];
          fen_d   = data_in[7];
          state_d = UIC_DONE;
        end
        UIC_EPEN_WR:
        begin
          epen_d  = data_in[`UIC_EPEN_BIT];
          state_d = UIC_DONE;
        end
        UIC_MODE_WR1:
        begin
          cfg_d   = data_in;
          state_d = UIC_MODE_WR2;
        end
        UIC_MODE_WR2:
        begin
          div_d   = data_in;
          state_d = UIC_DONE;
        end
        UIC_LTS_RW:
        begin
          epw_d      = 1'b1;
          epw_data_d = data_in;
          state_d    = UIC_DONE;
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
    else if (data_rd)
    begin
      case (state_q)
        UIC_FRAME_RD1:
        begin
          rd_d    = frame_number[7:0];
          state_d = UIC_FRAME_RD2;
        end
        UIC_FRAME_RD2:
        begin
          rd_d    = {5'h00, frame_number[10:8]};
          state_d = UIC_DONE;
        end
        UIC_SEL_RD:
        begin
          rd_d    = ep_select_status;
          state_d = UIC_DONE;
        end
        UIC_LTS_RW:
        begin
          rd_d    = ep_last_status;
          lts_d   = 1'b1;
          state_d = UIC_DONE;
        end
        UIC_EPS_RD:
        begin
          rd_d    = ep_status;
          state_d = UIC_DONE;
        end
        default:
        begin
          rd_d = 8'h00;
        end
      endcase
    end

    // Bus reset returns to default address with the function on; mode and divider are kept
    if (usb_bus_reset)
    begin
      addr_d = `UIC_ADDR_RST;
      fen_d  = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q    <= UIC_IDLE;
      addr_q     <= `UIC_ADDR_RST;
      fen_q      <= `UIC_FEN_RST;
      epen_q     <= 1'b0;
      cfg_q      <= `UIC_CFG_RST;
      div_q      <= `UIC_DIV_RST;
      rd_q       <= 8'h00;
      idx_q      <= 3'h0;
      sel_q      <= 1'b0;
      lts_q      <= 1'b0;
      epw_q      <= 1'b0;
      epw_data_q <= 8'h00;
      res_q      <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      addr_q     <= addr_d;
      fen_q      <= fen_d;
      epen_q     <= epen_d;
      cfg_q      <= cfg_d;
      div_q      <= div_d;
      rd_q       <= rd_d;
      idx_q      <= idx_d;
      sel_q      <= sel_d;
      lts_q      <= lts_d;
      epw_q      <= epw_d;
      epw_data_q <= epw_data_d;
      res_q      <= res_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign data_out                  = rd_q;
  assign ep_index                  = idx_q;
  assign ep_select_pulse           = sel_q;
  assign ep_last_status_rd         = lts_q;
  assign ep_status_wr              = epw_q;
  assign ep_status_wr_data         = epw_data_q;
  assign send_resume               = res_q;
  assign device_address            = addr_q;
  assign function_enable           = fen_q;
  assign control_endpoint_enable   = 1'b1;
  assign secondary_endpoint_enable = epen_q & fen_q;
  assign primary_endpoint_enable   = epen_q & fen_q;
  assign primary_endpoint_mode     = uic_epmode_t'(cfg_q[`UIC_CFG_EPMODE_HI:`UIC_CFG_EPMODE_LO]);
  assign nak_err_int_enable        = cfg_q[`UIC_CFG_NAKINT];
  assign internal_clk_run          = cfg_q[`UIC_CFG_CLKRUN] | ~usb_suspend;
  assign dplus_pullup_control      = cfg_q[`UIC_CFG_PULLUP] & vbus_present;
  assign must_be_one_bit           = div_q[6];

  uic_clock_output_pin_gen u_clock_output_pin
  (
    .sys_clk              (sys_clk),
    .reset_n              (reset_n),
    .output_divider_value (div_q[`UIC_DIV_VAL_HI:0]),
    .no_suspend_clk       (cfg_q[`UIC_CFG_NOSUSPCLK]),
    .usb_suspend          (usb_suspend),
    .clock_output_pin     (clock_output_pin)
  );

  uic_int_sel u_int
  (
    .sys_clk       (sys_clk),
    .reset_n       (reset_n),
    .int_reg_any   (int_reg_any),
    .sof_rx        (sof_rx),
    .sof_only_mode (div_q[`UIC_DIV_SOFONLY]),
    .int_pin_mode  (dma_int_pin_mode),
    .int_n         (int_n)
  );

endmodule : uic_cmd_init

//--- uic_cmd_props.sv
// Port assertions of the init command block
`timescale 1ns/1ps
module uic_cmd_props
  import uic_pkg::*;
(
  // Clock, reset and inputs
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        cmd_wr,
  input wire logic        data_wr,
  input wire logic [7:0]  data_in,
  input wire logic        usb_bus_reset,
  input wire logic        usb_suspend,
  input wire logic        vbus_present,
  // Outputs
  input wire logic [6:0]  device_address,
  input wire logic        function_enable,
  input wire logic        control_endpoint_enable,
  input wire logic        secondary_endpoint_enable,
  input wire uic_epmode_t primary_endpoint_mode,
  input wire logic        nak_err_int_enable,
  input wire logic        internal_clk_run,
  input wire logic        dplus_pullup_control,
  input wire logic [2:0]  ep_index,
  input wire logic        ep_select_pulse,
  input wire logic        send_resume
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////
  bus_rst_a:
    assert property (usb_bus_reset |=> device_address == 7'h00 && function_enable)
    else $error("bus reset left address or enable wrong");
  ctrl_ep_a: assert property (control_endpoint_enable)
    else $error("control endpoint disabled");
  ep_gate_a:
    assert property (!function_enable && $past(!function_enable) |-> !secondary_endpoint_enable)
    else $error("endpoints enabled without function");
  pullup_a: assert property (dplus_pullup_control |-> vbus_present)
    else $error("pull-up without bus power");
  clk_run_a: assert property (!usb_suspend |-> internal_clk_run)
    else $error("internal clocks stopped outside suspend");
  resume_a: assert property (send_resume == $past(cmd_wr && data_in == 8'hF6))
    else $error("resume pulse not tied to its command");
  ep_select_a:
    assert property (cmd_wr && data_in <= 8'h05 |=> ep_select_pulse && ep_index == $past(data_in[2:0]))
    else $error("endpoint select pulse or index wrong");
  mode_set_a:
    assert property ((cmd_wr && data_in == 8'hF3) ##1 (data_wr && !cmd_wr) |=>
      primary_endpoint_mode == $past(data_in[7:6]) && nak_err_int_enable == $past(data_in[3]))
    else $error("first mode byte not loaded");
endmodule : uic_cmd_props

bind uic_cmd_init uic_cmd_props uic_cmd_props_i (.sys_clk, .reset_n, .cmd_wr, .data_wr, .data_in,
  .usb_bus_reset, .usb_suspend, .vbus_present, .device_address, .function_enable, .control_endpoint_enable,
  .secondary_endpoint_enable, .primary_endpoint_mode, .nak_err_int_enable, .internal_clk_run,
  .dplus_pullup_control, .ep_index, .ep_select_pulse, .send_resume);

//--- uic_host_model.sv
// Host microcontroller model for the command bus
`timescale 1ns/1ps
module uic_host_model
#(
  parameter bit BUS_POWERED = 1'b0
)
(
  // Clock
  input  wire logic  sys_clk,
  // Command bus
  output logic       cmd_wr,
  output logic       data_wr,
  output logic       data_rd,
  output logic [7:0] data_in
);
  initial
  begin
    {cmd_wr, data_wr, data_rd} = 3'b000;
    data_in = 8'h00;
  end
  // One strobe a cycle, raised after the falling edge, held over the rising edge
  task automatic put(input logic [2:0] s, input logic [7:0] b);
    @(negedge sys_clk);
    {cmd_wr, data_wr, data_rd} = s;
    data_in = b;
    @(posedge sys_clk);
  endtask : put
  // Released bus carries the inverse of the last byte
  task automatic idle();
    @(negedge sys_clk);
    {cmd_wr, data_wr, data_rd} = 3'b000;
    data_in = ~data_in;
  endtask : idle
  // Reserved bits cleared, must-be-one bit set
  task automatic set_mode(input logic [7:0] cfg, input logic [7:0] div);
    put(3'b100, 8'hF3);
    put(3'b010, cfg & (BUS_POWERED ? 8'hDA : 8'hDE));
    put(3'b010, (div & 8'hCF) | 8'h40);
  endtask : set_mode
endmodule : uic_host_model

//--- usb_device_init_command_set_bench.sv
// Self-checking bench for the init command block
`timescale 1ns/1ps
module usb_device_init_command_set_bench
  import uic_pkg::*;
();
  int          failures = 0;
  int          checked = 0;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        usb_bus_reset = 1'b0;
  logic        usb_suspend = 1'b0;
  logic        vbus_present = 1'b1;
  logic        sof_rx = 1'b0;
  logic        int_reg_any = 1'b0;
  logic        dma_int_pin_mode = 1'b0;
  logic [10:0] frame_number = 11'h5A3;
  logic [7:0]  ep_select_status = 8'h00;
  logic [7:0]  ep_last_status = 8'h00;
  logic [7:0]  ep_status = 8'h00;
  logic [4:0]  tab [5] = '{5'b00100, 5'b00011, 5'b01010, 5'b10101, 5'b11010};
  wire         cmd_wr, data_wr, data_rd, ep_select_pulse, ep_last_status_rd, ep_status_wr;
  wire  [7:0]  data_in, data_out, ep_status_wr_data;
  wire  [6:0]  device_address;
  wire  [2:0]  ep_index;
  wire         send_resume, function_enable, control_endpoint_enable, secondary_endpoint_enable;
  wire         primary_endpoint_enable, nak_err_int_enable, internal_clk_run, dplus_pullup_control;
  wire         must_be_one_bit, clock_output_pin, int_n;
  uic_epmode_t primary_endpoint_mode;

  always #20 sys_clk = ~sys_clk;

  uic_host_model uic_host_model_i (.sys_clk, .cmd_wr, .data_wr, .data_rd, .data_in);
  uic_cmd_init uic_cmd_init_i (.sys_clk, .reset_n, .cmd_wr, .data_wr, .data_rd, .data_in, .data_out,
    .usb_bus_reset, .usb_suspend, .vbus_present, .sof_rx, .int_reg_any, .dma_int_pin_mode,
    .frame_number, .ep_select_status, .ep_last_status, .ep_status, .ep_index, .ep_select_pulse,
    .ep_last_status_rd, .ep_status_wr, .ep_status_wr_data, .send_resume, .device_address,
    .function_enable, .control_endpoint_enable, .secondary_endpoint_enable, .primary_endpoint_enable,
    .primary_endpoint_mode, .nak_err_int_enable, .internal_clk_run, .dplus_pullup_control,
    .must_be_one_bit, .clock_output_pin, .int_n);
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [10:0] s, input logic [10:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic cmd(input logic [7:0] b);
    uic_host_model_i.put(3'b100, b);
  endtask : cmd
  task automatic wr(input logic [7:0] b);
    uic_host_model_i.put(3'b010, b);
  endtask : wr
  task automatic rd();
    uic_host_model_i.put(3'b001, 8'h00);
    uic_host_model_i.idle();
  endtask : rd
  // Half period of the clock output in system cycles
  task automatic period(input int e);
    int n;
    logic p;
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      p = clock_output_pin;
      while (clock_output_pin === p && n < 1000)
      begin
        @(negedge sys_clk);
        n++;
      end
    end
    chk("clk half", n, e);
    if (n >= 1000)
      conclude();
  endtask : period
  ////////////////////////////////////////////////////////////////
  task automatic t_addr();
    chk("address", device_address, 0);
    chk("fn en", function_enable, 0);
    chk("ep mode", primary_endpoint_mode, 0);
    chk("nak", nak_err_int_enable, 1);
    chk("pullup", dplus_pullup_control, 0);
    period(12);
    cmd(8'hD0);
    wr(8'h85);
    wr(8'h12);
    uic_host_model_i.idle();
    chk("address", device_address, 5);
    chk("fn en", function_enable, 1);
    cmd(8'hD8);
    wr(8'h01);
    uic_host_model_i.idle();
    chk("ep2 en", primary_endpoint_enable, 1);
    cmd(8'hD0);
    wr(8'h05);
    uic_host_model_i.idle();
    chk("ep1 en", secondary_endpoint_enable, 0);
    chk("ep0 en", control_endpoint_enable, 1);
  endtask : t_addr
  task automatic t_mode();
    for (int m = 0; m < 4; m++)
    begin
      uic_host_model_i.set_mode({m[1:0], 2'b01, m[0], 3'b010}, 8'h43);
      uic_host_model_i.idle();
      usb_suspend = 1'b1;
      vbus_present = m[1];
      #1;
      chk("ep mode", primary_endpoint_mode, m[1:0]);
      chk("nak", nak_err_int_enable, m[0]);
      chk("pullup", dplus_pullup_control, m[1]);
      chk("clk run", internal_clk_run, 0);
    end
    period(4);
    usb_suspend = 1'b0;
    usb_bus_reset = 1'b1;
    repeat (2) @(negedge sys_clk);
    usb_bus_reset = 1'b0;
    chk("address", device_address, 0);
    chk("fn en", function_enable, 1);
    chk("nak", nak_err_int_enable, 1);
    chk("pullup", dplus_pullup_control, 1);
    period(4);
    cmd(8'hF3);
    wr(8'h40);
    cmd(8'hD0);
    wr(8'h03);
    uic_host_model_i.idle();
    chk("ep mode", primary_endpoint_mode, 1);
    chk("address", device_address, 3);
    chk("set one", must_be_one_bit, 1);
  endtask : t_mode
  task automatic t_reads();
    cmd(8'hF5);
    rd();
    chk("frame lo", data_out, 8'hA3);
    rd();
    chk("frame hi", data_out, 8'h05);
    for (int i = 0; i < 6; i++)
    begin
      ep_last_status = 8'h30 + i[7:0];
      ep_status = 8'hC0 + i[7:0];
      ep_select_status = 8'h60 + i[7:0];
      cmd(8'h40 + i[7:0]);
      rd();
      chk("last sts", data_out, 8'h30 + i[7:0]);
      chk("sts rd", ep_last_status_rd, 1);
      cmd(8'h80 + i[7:0]);
      rd();
      chk("ep sts", data_out, 8'hC0 + i[7:0]);
      chk("index", ep_index, i[2:0]);
      cmd(i[7:0]);
      @(negedge sys_clk);
      chk("sel pulse", ep_select_pulse, 1);
      rd();
      chk("sel sts", data_out, 8'h60 + i[7:0]);
      chk("sel pulse", ep_select_pulse, 0);
    end
    cmd(8'h43);
    wr(8'h5C);
    uic_host_model_i.idle();
    chk("sts wr", {ep_status_wr, ep_status_wr_data}, 9'h15C);
    cmd(8'hF6);
    uic_host_model_i.idle();
    chk("resume", send_resume, 1);
  endtask : t_reads
  task automatic t_clk();
    int n;
    uic_host_model_i.set_mode(8'h0C, 8'h43);
    uic_host_model_i.idle();
    usb_suspend = 1'b1;
    period(417);
    usb_suspend = 1'b0;
    uic_host_model_i.set_mode(8'h0E, 8'h4F);
    n = 0;
    repeat (40) @(negedge sys_clk);
    repeat (40)
    begin
      @(negedge sys_clk);
      n += (clock_output_pin !== 1'b0);
    end
    chk("clk off", n, 0);
    for (int k = 0; k < 5; k++)
    begin
      uic_host_model_i.set_mode(8'h0E, {tab[k][4], 7'h43});
      uic_host_model_i.idle();
      dma_int_pin_mode = tab[k][3];
      int_reg_any = tab[k][2];
      sof_rx = tab[k][1];
      @(negedge sys_clk);
      chk("int pin", int_n, tab[k][0]);
    end
  endtask : t_clk
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    t_addr();
    t_mode();
    t_reads();
    t_clk();
    conclude();
  end
endmodule : usb_device_init_command_set_bench
